// >>> hdl/dbsp_port_map.vh
// constants of the burst sram port: states, burst layout and pin idle levels
`ifndef DBSP_PORT_MAP_VH
`define DBSP_PORT_MAP_VH

// one-hot write capture states
`define DBSP_WR_IDLE   3'h1
`define DBSP_WR_WORD0  3'h2
`define DBSP_WR_WORD1  3'h4
`define DBSP_WR_IDLE_B 0
`define DBSP_WR_W0_B   1
`define DBSP_WR_W1_B   2

// one-hot read fetch states
`define DBSP_RD_IDLE   3'h1
`define DBSP_RD_WORD0  3'h2
`define DBSP_RD_WORD1  3'h4
`define DBSP_RD_IDLE_B 0
`define DBSP_RD_W0_B   1
`define DBSP_RD_W1_B   2

// burst word select within one loaded address
`define DBSP_BEAT0     1'h0
`define DBSP_BEAT1     1'h1

// pin levels
`define DBSP_OE_OFF    1'h1
`define DBSP_OE_ON     1'h0
`define DBSP_ECHO_RST  1'h0
`define DBSP_VALID_RST 1'h0
`define DBSP_CLEAR_BIT 1'h0

// read buffer fill levels
`define DBSP_BUF_EMPTY 2'h0
`define DBSP_BUF_FULL  2'h2

// words moved per loaded address, the only burst length
`define DBSP_BURST_WORDS 32'h2

`endif

// >>> hdl/dbsp_two_entry_buffer.v
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`include "dbsp_port_map.vh"
module dbsp_two_entry_buffer #(
  parameter W = 18
) (
  // clock and reset
  input  wire         clk,
  input  wire         resetn,
  // filling side
  input  wire         inValid,
  output wire         inReady,
  input  wire [W-1:0] inData,
  // draining side
  output wire         outValid,
  input  wire         outReady,
  output wire [W-1:0] outData
);

  reg [W-1:0] slot0_q;
  reg [W-1:0] slot1_q;
  reg [1:0]   count_q;
  wire        push;
  wire        pop;

  // slot0 is always the head, so outData needs no mux
  assign inReady  = (count_q != `DBSP_BUF_FULL);
  assign outValid = (count_q != `DBSP_BUF_EMPTY);
  assign outData  = slot0_q;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // shift-on-pop keeps both slots in order
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      slot0_q <= {W{`DBSP_CLEAR_BIT}};
      slot1_q <= {W{`DBSP_CLEAR_BIT}};
      count_q <= `DBSP_BUF_EMPTY;
    end
    else
    begin
      if (pop)
      begin
        slot0_q <= (count_q == `DBSP_BUF_FULL) ? slot1_q : inData;
        if (push && count_q == `DBSP_BUF_FULL)
          slot1_q <= inData;
      end
      else if (push)
      begin
        if (count_q == `DBSP_BUF_EMPTY)
          slot0_q <= inData;
        else
          slot1_q <= inData;
      end
      count_q <= count_q + {1'h0, push} - {1'h0, pop};
    end
  end

endmodule

// >>> hdl/dbsp_burst_sram_port.v
// device side of the double-data-rate two-word burst sram port
//
// Overview of operation
// - write words captured on both clock edges
// - read words driven one per clock edge
// - outputs released whenever no read data
// - same data pins carry write and read
// - address and direction latched with load strobe
// - every transaction moves exactly two words, except a read load during a stalled fetch, which is dropped
// - direction high reads, low writes
// - address sampled only at positive edge
// - byte selects ride with data, deasserted keeps
// - valid flag high while read data out
`timescale 1ns/1ps
`include "dbsp_port_map.vh"
module dbsp_burst_sram_port #(
  parameter DW  = 18,
  parameter BW  = 9,
  parameter AW  = 20
) (
  // clock and reset
  input  wire             clk,
  input  wire             resetn,
  // input clock edge strobes, one clk cycle each
  input  wire             kRise,
  input  wire             kbRise,
  // transaction definition
  input  wire             loadStrobeN,
  input  wire             readNotWrite,
  input  wire [AW-1:0]    addr,
  // shared data pins, split into in, out and enable
  input  wire [DW-1:0]    dqIn,
  output wire [DW-1:0]    dqOut,
  output wire             dqOeN,
  input  wire [DW/BW-1:0] byteWriteSelectN,
  // output status
  output wire             readValidFlag,
  output wire             echoClock
);

  localparam NB    = DW / BW;
  // one burst of words behind every loaded address
  localparam DEPTH = `DBSP_BURST_WORDS << AW;

  // memory core: two words per loaded address
  reg [DW-1:0] mem [0:DEPTH-1];

  reg [2:0]    wrState_q;
  reg [AW-1:0] wrAddr_q;
  reg [2:0]    rdState_q;
  reg [AW-1:0] rdAddr_q;
  reg [DW-1:0] dqOut_q;
  reg          dqOeN_q;
  reg          readValid_q;
  reg          echo_q;

  wire          loadK;
  wire          newWrite;
  wire          newRead;
  wire          capture;
  wire          captureBeat;
  wire          srcValid;
  wire          srcReady;
  wire          srcBeat;
  wire [DW-1:0] srcData;
  wire          bufValid;
  wire          bufPop;
  wire [DW-1:0] bufData;
  wire          anyEdge;

  // memory word index from loaded address and beat
  function [AW:0] wordIndex;
    input [AW-1:0] a;
    input          beat;
    begin
      wordIndex = {a, beat};
    end
  endfunction

  // merge new data into old word under active-low byte selects
  function [DW-1:0] byteMerge;
    input [DW-1:0] oldW;
    input [DW-1:0] newW;
    input [NB-1:0] selN;
    integer b;
    begin
      byteMerge = oldW;
      for (b = 0; b < NB; b = b + 1)
        if (!selN[b])
          byteMerge[b*BW +: BW] = newW[b*BW +: BW];
    end
  endfunction

  // a transaction is only defined at a positive edge with the strobe low
  assign loadK    = kRise & ~loadStrobeN;
  assign newWrite = loadK & ~readNotWrite;
  assign newRead  = loadK & readNotWrite;
  assign anyEdge  = kRise | kbRise;

  // write beat 0 comes on the negative edge, beat 1 on the next positive edge
  assign capture     = (wrState_q[`DBSP_WR_W0_B] & kbRise) | (wrState_q[`DBSP_WR_W1_B] & kRise);
  assign captureBeat = wrState_q[`DBSP_WR_W1_B] ? `DBSP_BEAT1 : `DBSP_BEAT0;

  // write sequencing: exactly two beats per loaded address
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrState_q <= `DBSP_WR_IDLE;
      wrAddr_q  <= {AW{`DBSP_CLEAR_BIT}};
    end
    else
    begin
      case (1'h1)
        wrState_q[`DBSP_WR_IDLE_B]:
        begin
          if (newWrite)
          begin
            wrState_q <= `DBSP_WR_WORD0;
            wrAddr_q  <= addr;
          end
        end
        wrState_q[`DBSP_WR_W0_B]:
        begin
          if (kbRise)
            wrState_q <= `DBSP_WR_WORD1;
        end
        wrState_q[`DBSP_WR_W1_B]:
        begin
          // the closing positive edge may already open the next write
          if (kRise)
          begin
            wrState_q <= newWrite ? `DBSP_WR_WORD0 : `DBSP_WR_IDLE;
            if (newWrite)
              wrAddr_q <= addr;
          end
        end
        default:
          wrState_q <= `DBSP_WR_IDLE;
      endcase
    end
  end

  // core write with byte masking; memory itself has no reset
  always @(posedge clk)
  begin
    if (capture)
      mem[wordIndex(wrAddr_q, captureBeat)] <=
        byteMerge(mem[wordIndex(wrAddr_q, captureBeat)], dqIn, byteWriteSelectN);
  end

  // read fetch pushes two words into the buffer, stalling while it is full
  assign srcValid = rdState_q[`DBSP_RD_W0_B] | rdState_q[`DBSP_RD_W1_B];
  assign srcBeat  = rdState_q[`DBSP_RD_W1_B] ? `DBSP_BEAT1 : `DBSP_BEAT0;
  assign srcData  = mem[wordIndex(rdAddr_q, srcBeat)];

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdState_q <= `DBSP_RD_IDLE;
      rdAddr_q  <= {AW{`DBSP_CLEAR_BIT}};
    end
    else
    begin
      case (1'h1)
        rdState_q[`DBSP_RD_IDLE_B]:
        begin
          if (newRead)
          begin
            rdState_q <= `DBSP_RD_WORD0;
            rdAddr_q  <= addr;
          end
        end
        rdState_q[`DBSP_RD_W0_B]:
        begin
          if (srcReady)
            rdState_q <= `DBSP_RD_WORD1;
        end
        rdState_q[`DBSP_RD_W1_B]:
        begin
          if (srcReady)
          begin
            rdState_q <= newRead ? `DBSP_RD_WORD0 : `DBSP_RD_IDLE;
            if (newRead)
              rdAddr_q <= addr;
          end
          else if (newRead)
          begin
            // a stalled fetch cannot take a new load; it is dropped
            rdState_q <= `DBSP_RD_WORD1;
          end
        end
        default:
          rdState_q <= `DBSP_RD_IDLE;
      endcase
    end
  end

  // the buffer absorbs the gap between fetch and the next clock edge
  dbsp_two_entry_buffer #(
    .W (DW)
  ) u_readBuffer (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (srcValid),
    .inReady  (srcReady),
    .inData   (srcData),
    .outValid (bufValid),
    .outReady (anyEdge),
    .outData  (bufData)
  );

  assign bufPop = bufValid & anyEdge;

  // output stage updates only on input clock edges, one word per edge
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dqOut_q     <= {DW{`DBSP_CLEAR_BIT}};
      dqOeN_q     <= `DBSP_OE_OFF;
      readValid_q <= `DBSP_VALID_RST;
      echo_q      <= `DBSP_ECHO_RST;
    end
    else
    begin
      if (anyEdge)
      begin
        if (bufPop)
          dqOut_q <= bufData;
        dqOeN_q     <= bufPop ? `DBSP_OE_ON : `DBSP_OE_OFF;
        readValid_q <= bufPop;
        echo_q      <= kRise;
      end
    end
  end

  assign dqOut         = dqOut_q;
  assign dqOeN         = dqOeN_q;
  assign readValidFlag = readValid_q;
  assign echoClock     = echo_q;

endmodule

// >>> verification/dbsp_port_asserts.sv
// pin-level assertions for the burst sram port
`timescale 1ns/1ps
module dbsp_port_asserts #(
  parameter DW = 18,
  parameter BW = 9,
  parameter AW = 20
) (
  // clock, reset and edge strobes
  input logic             clk,
  input logic             resetn,
  input logic             kRise,
  input logic             kbRise,
  // transaction, pins and status
  input logic             loadStrobeN,
  input logic             readNotWrite,
  input logic             dqOeN,
  input logic             readValidFlag,
  input logic             echoClock,
  input logic [AW-1:0]    addr,
  input logic [DW-1:0]    dqIn,
  input logic [DW-1:0]    dqOut,
  input logic [DW/BW-1:0] byteWriteSelectN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  oe_valid_a: assert property (dqOeN == !readValidFlag)
    else $error("enable and valid differ");
  echo_high_a: assert property (kRise |=> echoClock)
    else $error("echo not high");
  echo_low_a: assert property (kbRise |=> !echoClock)
    else $error("echo not low");
  out_hold_a: assert property (!kRise && !kbRise |=> $stable(dqOut) && $stable(readValidFlag))
    else $error("output moved off an edge");
  read_pair_a: assert property (kRise && !loadStrobeN && readNotWrite ##1 kbRise ##1 kRise
    |=> readValidFlag ##1 readValidFlag) else $error("read burst not two words");
  read_cause_a: assert property ($rose(readValidFlag) |->
    $past(kRise, 3) && !$past(loadStrobeN, 3) && $past(readNotWrite, 3)) else $error("valid without read load");
  idle_off_a: assert property (kRise && (loadStrobeN || !readNotWrite) ##1 kbRise ##1 kRise |=> dqOeN)
    else $error("pins driven when idle");
  off_edge_a: assert property ($fell(readValidFlag) |-> $past(kRise))
    else $error("release off positive edge");
endmodule

bind dbsp_burst_sram_port dbsp_port_asserts #(.DW(DW), .BW(BW), .AW(AW)) chk (.clk(clk), .resetn(resetn),
  .kRise(kRise), .kbRise(kbRise), .loadStrobeN(loadStrobeN), .readNotWrite(readNotWrite), .addr(addr),
  .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN), .byteWriteSelectN(byteWriteSelectN),
  .readValidFlag(readValidFlag), .echoClock(echoClock));

// >>> verification/dbsp_ctrl_model.sv
// controller side: input clock edge strobes and the shared data wire
`timescale 1ns/1ps
module dbsp_ctrl_model #(parameter DW = 18) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // both input clocks stand still while hold is high
  input wire hold,
  // edge strobes
  output wire kRise,
  output wire kbRise,
  // shared pins
  input wire [DW-1:0] ctrlData,
  input wire [DW-1:0] dqOut,
  input wire dqOeN,
  output wire [DW-1:0] dqIn
);
  reg phase_q;
  // edges alternate, positive first; changing on posedge keeps them steady at negedge
  always @(posedge clk or negedge resetn)
    if (!resetn)
      phase_q <= 1'h0;
    else if (!hold)
      phase_q <= ~phase_q;
  // a paused pair resumes with the edge that was due next
  assign kRise = ~phase_q & ~hold;
  assign kbRise = phase_q & ~hold;
  // wire level: the device wins while it drives
  assign dqIn = dqOeN ? ctrlData : dqOut;
endmodule

// >>> verification/dbsp_burst_sram_port_bench.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module dbsp_burst_sram_port_bench;
  logic clk = 1'h0, resetn = 1'h0, loadStrobeN = 1'h1, readNotWrite = 1'h0, hold = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [17:0] ctrlData = 18'h00000, dqIn, dqOut;
  logic [1:0] bwsN = 2'h3;
  logic kRise, kbRise, dqOeN, readValidFlag, echoClock;
  int bad_count = 0, num_checks = 0;
  always #10 clk = ~clk;
  dbsp_ctrl_model #(.DW(18)) ctrl (.clk(clk), .resetn(resetn), .hold(hold), .kRise(kRise), .kbRise(kbRise),
    .ctrlData(ctrlData), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn));
  dbsp_burst_sram_port #(.DW(18), .BW(9), .AW(4)) DUT (.clk(clk), .resetn(resetn), .kRise(kRise),
    .kbRise(kbRise), .loadStrobeN(loadStrobeN), .readNotWrite(readNotWrite), .addr(addr), .dqIn(dqIn),
    .dqOut(dqOut), .dqOeN(dqOeN), .byteWriteSelectN(bwsN), .readValidFlag(readValidFlag),
    .echoClock(echoClock));
  task chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // move to the slot before a positive edge; bounded, a lost edge ends the run
  task to_k;
    @(negedge clk);
    if (!kRise)
      @(negedge clk);
    if (kRise !== 1'h1)
    begin
      bad_count++;
      report_and_stop;
    end
  endtask
  // starts in a positive slot, returns in the beat1 slot so a next load may share it
  task wr(input logic [3:0] a, input logic [17:0] d0, d1, input logic [1:0] m1);
    loadStrobeN = 1'h0;
    readNotWrite = 1'h0;
    addr = a;
    @(negedge clk);
    loadStrobeN = 1'h1;
    ctrlData = d0;
    bwsN = 2'h0;
    @(negedge clk);
    ctrlData = d1;
    bwsN = m1;
  endtask
  // read burst: both words, echo level, then release
  task rd(input logic [3:0] a, input logic [17:0] e0, e1);
    to_k;
    loadStrobeN = 1'h0;
    readNotWrite = 1'h1;
    addr = a;
    @(negedge clk);
    loadStrobeN = 1'h1;
    repeat (2) @(negedge clk);
    chk(dqOut, e0);
    chk({15'h0000, dqOeN, readValidFlag, echoClock}, 18'h00003);
    @(negedge clk);
    chk(dqIn, e1);
    chk({16'h0000, readValidFlag, echoClock}, 18'h00002);
    @(negedge clk);
    chk({16'h0000, dqOeN, readValidFlag}, 18'h00002);
  endtask
  // a low strobe in a negative slot only must start nothing
  task kb_load;
    to_k;
    @(negedge clk);
    readNotWrite = 1'h1;
    loadStrobeN = 1'h0;
    @(negedge clk);
    loadStrobeN = 1'h1;
    repeat (3) @(negedge clk);
    chk({16'h0000, dqOeN, readValidFlag}, 18'h00002);
  endtask
  // paused input clocks: nothing is captured or driven until the due edge arrives
  task gap_wr(input logic [17:0] d0, d1);
    to_k;
    loadStrobeN = 1'h0;
    readNotWrite = 1'h0;
    addr = 4'h5;
    @(negedge clk);
    loadStrobeN = 1'h1;
    hold = 1'h1;
    ctrlData = 18'h3FFFF;
    bwsN = 2'h0;
    repeat (3) @(negedge clk);
    chk(dqOut, 18'h0AAE7);
    chk({15'h0000, dqOeN, readValidFlag, echoClock}, 18'h00005);
    hold = 1'h0;
    ctrlData = d0;
    @(negedge clk);
    ctrlData = d1;
    rd(4'h5, d0, d1);
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    chk(dqOut, 18'h00000);
    chk({15'h0000, dqOeN, readValidFlag, echoClock}, 18'h00004);
    resetn = 1'h1;
    to_k;
    wr(4'h3, 18'h2A5C3, 18'h1B4E7, 2'h0);
    wr(4'h9, 18'h3FFFF, 18'h00001, 2'h0);
    rd(4'h3, 18'h2A5C3, 18'h1B4E7);
    rd(4'h9, 18'h3FFFF, 18'h00001);
    to_k;
    wr(4'h3, 18'h11111, 18'h0AAAA, 2'h1);
    rd(4'h3, 18'h11111, {9'h055, 9'h0E7});
    kb_load;
    gap_wr(18'h0C0DE, 18'h21357);
    report_and_stop;
  end
endmodule
